/* src/sps_pkg.sv */
// shared constants and types for the serial packet slave framer
package sps_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned BAUD_BPS        = 38_400;
  localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  // cycles per serial bit, 10 MHz / 38400 = 260.4, held to 260 (0.16 % fast)
  localparam logic [8:0]  BIT_CYCLES      = 9'(CLK_HZ / BAUD_BPS);
  localparam logic [8:0]  HALF_BIT_CYCLES = 9'(CLK_HZ / BAUD_BPS / 2);
  localparam logic [3:0]  DATA_BITS       = 4'h8;
  localparam logic [3:0]  STOP_BIT_IDX    = 4'h9;
  // longest gap between characters of one packet; a longest time rounds down
  localparam int unsigned CHAR_GAP_NS     = 2_000_000;
  localparam int unsigned CHAR_GAP_CYCLES = CHAR_GAP_NS / CLK_PERIOD_NS;
  // longest time from last command character to the answer; rounds down
  localparam int unsigned RESP_TIME_NS    = 2_000_000;
  localparam int unsigned RESP_CYCLES     = RESP_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  ACK_BYTE        = 8'h06;
  localparam logic [7:0]  BCAST_ADDR      = 8'h00;
  localparam logic [7:0]  MAX_MSG_LEN     = 8'h30;

  typedef enum logic [7:0] {
    ST_CMD  = 8'h01,
    ST_ADDR = 8'h02,
    ST_LEN  = 8'h04,
    ST_MSG  = 8'h08,
    ST_SUM  = 8'h10,
    ST_WAIT = 8'h20,
    ST_TX   = 8'h40,
    ST_END  = 8'h80
  } sps_state_t;

  typedef enum logic [4:0] {
    PH_ACK  = 5'h01,
    PH_ADDR = 5'h02,
    PH_LEN  = 5'h04,
    PH_DATA = 5'h08,
    PH_SUM  = 5'h10
  } sps_phase_t;
endpackage

/* src/sps_uart_if.sv */
// byte-level link between the framer core and its serial engine
interface sps_uart_if;
  logic       rx_line;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       rx_ferr;
  logic       tx_start;
  logic [7:0] tx_data;
  logic       tx_busy;
  logic       tx_line;

  modport core (output rx_line, tx_start, tx_data,
                input  rx_valid, rx_data, rx_ferr, tx_busy, tx_line);
  modport phy  (input  rx_line, tx_start, tx_data,
                output rx_valid, rx_data, rx_ferr, tx_busy, tx_line);
endinterface

/* src/sps_uart.sv */
// 8N1 serial receiver and transmitter at the fixed bit rate
module sps_uart
  import sps_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  sps_uart_if.phy   bus
);
  logic [8:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [7:0] rx_shift;
  logic       rx_busy;
  logic [8:0] tx_cnt;
  logic [3:0] tx_bit;
  logic [8:0] tx_shift;

  // receiver: sample each bit at its middle, start bit rechecked to reject glitches
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_busy     <= 1'b0;
      rx_cnt      <= 9'h000;
      rx_bit      <= 4'h0;
      rx_shift    <= 8'h00;
      bus.rx_valid <= 1'b0;
      bus.rx_data  <= 8'h00;
      bus.rx_ferr  <= 1'b0;
    end else begin
      bus.rx_valid <= 1'b0;
      if (!rx_busy) begin
        if (!bus.rx_line) begin
          rx_busy <= 1'b1;
          rx_cnt  <= HALF_BIT_CYCLES - 9'h001;
          rx_bit  <= 4'h0;
        end
      end else if (rx_cnt != 9'h000) begin
        rx_cnt <= rx_cnt - 9'h001;
      end else begin
        rx_cnt <= BIT_CYCLES - 9'h001;
        if (rx_bit == 4'h0) begin
          if (bus.rx_line) begin
            rx_busy <= 1'b0;
          end else begin
            rx_bit <= 4'h1;
          end
        end else if (rx_bit <= DATA_BITS) begin
          rx_shift <= {bus.rx_line, rx_shift[7:1]};
          rx_bit   <= rx_bit + 4'h1;
        end else begin
          // a low stop bit is a framing error
          bus.rx_valid <= 1'b1;
          bus.rx_data  <= rx_shift;
          bus.rx_ferr  <= !bus.rx_line;
          rx_busy      <= 1'b0;
        end
      end
    end
  end

  // transmitter: start bit, eight data bits lsb first, one stop bit
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus.tx_busy <= 1'b0;
      bus.tx_line <= 1'b1;
      tx_cnt      <= 9'h000;
      tx_bit      <= 4'h0;
      tx_shift    <= 9'h1ff;
    end else if (!bus.tx_busy) begin
      if (bus.tx_start) begin
        bus.tx_busy <= 1'b1;
        bus.tx_line <= 1'b0;
        tx_shift    <= {1'b1, bus.tx_data};
        tx_cnt      <= BIT_CYCLES - 9'h001;
        tx_bit      <= 4'h0;
      end
    end else if (tx_cnt != 9'h000) begin
      tx_cnt <= tx_cnt - 9'h001;
    end else begin
      tx_cnt <= BIT_CYCLES - 9'h001;
      if (tx_bit == STOP_BIT_IDX) begin
        bus.tx_busy <= 1'b0;
      end else begin
        bus.tx_line <= tx_shift[0];
        tx_shift    <= {1'b1, tx_shift[8:1]};
        tx_bit      <= tx_bit + 4'h1;
      end
    end
  end
endmodule // sps_uart

/* src/sps_framer.sv */
// slave-side packet framer and responder for the addressed serial protocol
// Notes on behaviour
// - transmit only when answering a just-received command
// - 38400 baud, eight data bits, no parity, one stop
// - half duplex: receive whole packet before replying
// - act only on packets addressed to own unit or to broadcast 0x00
// - length byte counts message bytes before checksum
// - last byte is modulo-256 sum of preceding bytes
// - successful no-data command answered with 0x06
// - broadcast address 0x00 executed but never answered
// - reply: own address, length, data, checksum
// - on any error discard packet, stay silent
// - never send a negative acknowledge
// - check field order, address, gaps and checksum
// - every numeric field travels as bytes
// - character gap above 2 ms is an error
// - answer must begin within 2 ms
// - messages longer than 48 bytes rejected
// - address 0x00 accepted whatever the unit address
module sps_framer
  import sps_pkg::*;
#(
  parameter int unsigned CHAR_GAP_CYC = CHAR_GAP_CYCLES,
  parameter int unsigned RESP_CYC     = RESP_CYCLES
)(
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       rx_in,
  output logic            tx_out,
  output logic            tx_oe_out,
  input  wire logic [7:0] unit_addr_in,
  output logic            cmd_valid_out,
  output logic [7:0]      cmd_out,
  output logic            cmd_bcast_out,
  output logic [7:0]      cmd_len_out,
  output logic            msg_valid_out,
  output logic [7:0]      msg_data_out,
  output logic [5:0]      msg_index_out,
  output logic            drop_out,
  input  wire logic       resp_ack_in,
  input  wire logic       resp_start_in,
  input  wire logic [7:0] resp_len_in,
  input  wire logic       resp_valid_in,
  input  wire logic [7:0] resp_data_in,
  output logic            resp_ready_out
);
  sps_uart_if uart_bus();

  sps_state_t state;
  sps_phase_t phase;
  logic [7:0]  sum;
  logic [7:0]  remain;
  logic [5:0]  idx;
  logic        mine;
  logic        bcast;
  logic [15:0] gap_cnt;
  logic [15:0] resp_cnt;
  logic        gap_expired;
  logic        resp_expired;
  logic        in_packet;
  logic        can_send;
  logic        rx_good;

  assign uart_bus.rx_line = rx_in;
  assign tx_out           = uart_bus.tx_line;
  assign in_packet        = (state == ST_ADDR) || (state == ST_LEN) ||
                            (state == ST_MSG)  || (state == ST_SUM);
  assign rx_good          = uart_bus.rx_valid && !uart_bus.rx_ferr;
  // start only when the engine is idle and no start is in flight
  assign can_send         = !uart_bus.tx_start && !uart_bus.tx_busy;
  assign gap_expired      = (gap_cnt == 16'(CHAR_GAP_CYC - 1));
  assign resp_expired     = (resp_cnt == 16'(RESP_CYC - 1));

  sps_uart u_uart (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .bus      (uart_bus.phy)
  );

  // time since the last character of the packet under reception
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap_cnt <= 16'h0000;
    end else if (!in_packet || uart_bus.rx_valid) begin
      gap_cnt <= 16'h0000;
    end else if (!gap_expired) begin
      gap_cnt <= gap_cnt + 16'h0001;
    end
  end

  // time since the checksum byte while the application prepares its answer
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      resp_cnt <= 16'h0000;
    end else if (state != ST_WAIT) begin
      resp_cnt <= 16'h0000;
    end else if (!resp_expired) begin
      resp_cnt <= resp_cnt + 16'h0001;
    end
  end

  // packet reception, checking and answering
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state             <= ST_CMD;
      phase             <= PH_ACK;
      sum               <= 8'h00;
      remain            <= 8'h00;
      idx               <= 6'h00;
      mine              <= 1'b0;
      bcast             <= 1'b0;
      tx_oe_out         <= 1'b0;
      uart_bus.tx_start <= 1'b0;
      uart_bus.tx_data  <= 8'h00;
      resp_ready_out    <= 1'b0;
      cmd_valid_out     <= 1'b0;
      cmd_out           <= 8'h00;
      cmd_bcast_out     <= 1'b0;
      cmd_len_out       <= 8'h00;
      msg_valid_out     <= 1'b0;
      msg_data_out      <= 8'h00;
      msg_index_out     <= 6'h00;
      drop_out          <= 1'b0;
    end else begin
      uart_bus.tx_start <= 1'b0;
      cmd_valid_out     <= 1'b0;
      msg_valid_out     <= 1'b0;
      drop_out          <= 1'b0;
      if (in_packet && (gap_expired || (uart_bus.rx_valid && uart_bus.rx_ferr))) begin
        // timeout or bad character: drop the partial packet silently
        drop_out <= mine;
        mine     <= 1'b0;
        sum      <= 8'h00;
        state    <= ST_CMD;
      end else begin
        unique case (state)
          ST_CMD, ST_WAIT: begin
            if (rx_good) begin
              // first byte is always the command byte
              cmd_out <= uart_bus.rx_data;
              sum     <= uart_bus.rx_data;
              mine    <= 1'b0;
              state   <= ST_ADDR;
            end else if (state == ST_WAIT) begin
              if (resp_expired) begin
                state <= ST_CMD;
              end else if (resp_ack_in) begin
                phase     <= PH_ACK;
                tx_oe_out <= 1'b1;
                state     <= ST_TX;
              end else if (resp_start_in && resp_len_in <= MAX_MSG_LEN) begin
                phase     <= PH_ADDR;
                remain    <= resp_len_in;
                tx_oe_out <= 1'b1;
                state     <= ST_TX;
              end
            end
          end
          ST_ADDR: begin
            if (rx_good) begin
              // broadcast accepted regardless of unit address
              mine  <= (uart_bus.rx_data == unit_addr_in) ||
                       (uart_bus.rx_data == BCAST_ADDR);
              bcast <= (uart_bus.rx_data == BCAST_ADDR);
              sum   <= sum + uart_bus.rx_data;
              state <= ST_LEN;
            end
          end
          ST_LEN: begin
            if (rx_good) begin
              if (uart_bus.rx_data > MAX_MSG_LEN) begin
                drop_out <= mine;
                mine     <= 1'b0;
                state    <= ST_CMD;
              end else begin
                cmd_len_out <= uart_bus.rx_data;
                remain      <= uart_bus.rx_data;
                idx         <= 6'h00;
                sum         <= sum + uart_bus.rx_data;
                state       <= (uart_bus.rx_data == 8'h00) ? ST_SUM : ST_MSG;
              end
            end
          end
          ST_MSG: begin
            if (rx_good) begin
              // bytes stream out early; the application discards them on drop_out
              msg_valid_out <= mine;
              msg_data_out  <= uart_bus.rx_data;
              msg_index_out <= idx;
              idx           <= idx + 6'h01;
              remain        <= remain - 8'h01;
              sum           <= sum + uart_bus.rx_data;
              if (remain == 8'h01) begin
                state <= ST_SUM;
              end
            end
          end
          ST_SUM: begin
            if (rx_good) begin
              if (mine && uart_bus.rx_data == sum) begin
                cmd_valid_out <= 1'b1;
                cmd_bcast_out <= bcast;
                // broadcast: executed but no answer window opened
                state         <= bcast ? ST_CMD : ST_WAIT;
              end else begin
                drop_out <= mine;
                state    <= ST_CMD;
              end
              mine <= 1'b0;
            end
          end
          ST_TX: begin
            // incoming characters are ignored while answering
            if (phase == PH_DATA) begin
              if (resp_ready_out && resp_valid_in) begin
                resp_ready_out    <= 1'b0;
                uart_bus.tx_start <= 1'b1;
                uart_bus.tx_data  <= resp_data_in;
                sum               <= sum + resp_data_in;
                remain            <= remain - 8'h01;
                if (remain == 8'h01) begin
                  phase <= PH_SUM;
                end
              end else if (can_send) begin
                resp_ready_out <= 1'b1;
              end
            end else if (can_send) begin
              uart_bus.tx_start <= 1'b1;
              unique case (phase)
                PH_ACK: begin
                  uart_bus.tx_data <= ACK_BYTE;
                  state            <= ST_END;
                end
                PH_ADDR: begin
                  uart_bus.tx_data <= unit_addr_in;
                  sum              <= unit_addr_in;
                  phase            <= PH_LEN;
                end
                PH_LEN: begin
                  uart_bus.tx_data <= remain;
                  sum              <= sum + remain;
                  phase            <= (remain == 8'h00) ? PH_SUM : PH_DATA;
                end
                PH_SUM: begin
                  uart_bus.tx_data <= sum;
                  state            <= ST_END;
                end
                default: begin
                  uart_bus.tx_data <= sum;
                  state            <= ST_END;
                end
              endcase
            end
          end
          ST_END: begin
            // release the shared line once the last stop bit is out
            if (can_send) begin
              tx_oe_out <= 1'b0;
              state     <= ST_CMD;
            end
          end
          default: begin
            state <= ST_CMD;
          end
        endcase
      end
    end
  end
endmodule // sps_framer

/* bench/sps_checker.sv */
// port-level assertions for the serial packet slave framer
module sps_checker #(
  parameter int unsigned CHAR_GAP_CYC = 4000,
  parameter int unsigned RESP_CYC     = 4000
)(
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       tx_out,
  input  wire logic       tx_oe_out,
  input  wire logic       cmd_valid_out,
  input  wire logic       cmd_bcast_out,
  input  wire logic       msg_valid_out,
  input  wire logic [5:0] msg_index_out,
  input  wire logic       drop_out,
  input  wire logic       resp_ack_in,
  input  wire logic       resp_start_in,
  input  wire logic       resp_valid_in,
  input  wire logic       resp_ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // quiet: nothing answerable since reset, a broadcast or a drop
  logic        quiet;
  logic [31:0] since_cmd;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) quiet <= 1'b1;
    else if (cmd_valid_out) quiet <= cmd_bcast_out;
    else if (drop_out) quiet <= 1'b1;
  end
  // saturates so a long idle spell cannot wrap into a false pass
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) since_cmd <= '1;
    else if (cmd_valid_out) since_cmd <= '0;
    else if (since_cmd != '1) since_cmd <= since_cmd + 32'h1;
  end
  a_idle_high: assert property (!tx_oe_out |-> tx_out)
    else $error("tx line low while not driven");
  a_oe_cause: assert property ($rose(tx_oe_out) |->
      $past(resp_ack_in) || $past(resp_start_in))
    else $error("transmit began without a request");
  a_start_low: assert property ($rose(tx_oe_out) |-> ##2 !tx_out [*8])
    else $error("no start bit after enable");
  a_half_dup: assert property (tx_oe_out |-> !cmd_valid_out && !msg_valid_out)
    else $error("receive event while transmitting");
  a_err_silent: assert property (quiet |-> !tx_oe_out)
    else $error("transmit without an answerable command");
  a_resp_time: assert property ($rose(tx_oe_out) |-> since_cmd <= RESP_CYC + 1)
    else $error("answer started too late");
  a_len_max: assert property (msg_valid_out |-> msg_index_out < 6'h30)
    else $error("message index beyond limit");
  a_ready_drop: assert property (resp_valid_in && resp_ready_out |=> !resp_ready_out)
    else $error("ready held after byte taken");
  c_tx: cover property ($rose(tx_oe_out));
  c_bcast: cover property (cmd_valid_out && cmd_bcast_out);
  c_drop: cover property (drop_out);
  c_data: cover property (resp_valid_in && resp_ready_out);
endmodule // sps_checker

bind sps_framer sps_checker #(.CHAR_GAP_CYC(CHAR_GAP_CYC), .RESP_CYC(RESP_CYC)) i_sps_checker (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .tx_out(tx_out), .tx_oe_out(tx_oe_out),
  .cmd_valid_out(cmd_valid_out), .cmd_bcast_out(cmd_bcast_out),
  .msg_valid_out(msg_valid_out), .msg_index_out(msg_index_out), .drop_out(drop_out),
  .resp_ack_in(resp_ack_in), .resp_start_in(resp_start_in),
  .resp_valid_in(resp_valid_in), .resp_ready_out(resp_ready_out));

/* bench/sps_master.sv */
// master terminal model on the shared serial line
module sps_master
  import sps_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic tx_in,
  output logic      line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial line_out = 1'b1;
  // one 8N1 character, lsb first; next start follows the stop directly
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out = fr[i];
      repeat (BIT_CYCLES) @(negedge mclk_in);
    end
  endtask
  // bad is xored into the checksum to corrupt it on purpose
  task automatic send_pkt(input logic [7:0] cmd, adr, input logic [7:0] msg[$],
                          input logic [7:0] bad);
    logic [7:0] sum;
    sum = cmd + adr + 8'(msg.size());
    send_byte(cmd);
    send_byte(adr);
    send_byte(8'(msg.size()));
    foreach (msg[i]) begin
      send_byte(msg[i]);
      sum += msg[i];
    end
    send_byte(sum ^ bad);
  endtask
  // silence is a legal outcome; ok stays 0 then
  task automatic recv_byte(output logic [7:0] b, output bit ok);
    int n;
    ok = 1'b0;
    b = 8'h00;
    for (n = 0; n < 6000 && tx_in !== 1'b0; n++) @(negedge mclk_in);
    if (tx_in !== 1'b0) return;
    repeat (HALF_BIT_CYCLES) @(negedge mclk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(negedge mclk_in);
      b[i] = tx_in;
    end
    repeat (BIT_CYCLES) @(negedge mclk_in);
    ok = (tx_in === 1'b1);
    // return just as the stop bit ends: no overlap on the line, next start not missed
    repeat (HALF_BIT_CYCLES) @(negedge mclk_in);
  endtask
endmodule // sps_master

/* bench/sps_framer_tb.sv */
// self-checking bench for the serial packet slave framer
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module sps_framer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sps_pkg::*;
  localparam int unsigned GAP  = 3000;
  localparam int unsigned CEIL = 110000;
  logic       mclk_in, rst_n_in, rx_in, tx_out, tx_oe_out, cmd_valid_out, cmd_bcast_out;
  logic       msg_valid_out, drop_out, resp_ack_in, resp_start_in, resp_valid_in;
  logic       resp_ready_out;
  logic [7:0] unit_addr_in, cmd_out, cmd_len_out, msg_data_out, resp_len_in, resp_data_in;
  logic [5:0] msg_index_out;
  logic [7:0] got_msg[$], rx_q[$], e[$];
  int         num_errors = 0, checks_done = 0, n_cmd = 0, n_drop = 0, n_oe = 0, cyc = 0;

  sps_framer #(.CHAR_GAP_CYC(GAP), .RESP_CYC(GAP)) i_sps_framer (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .rx_in(rx_in), .tx_out(tx_out),
    .tx_oe_out(tx_oe_out), .unit_addr_in(unit_addr_in), .cmd_valid_out(cmd_valid_out),
    .cmd_out(cmd_out), .cmd_bcast_out(cmd_bcast_out), .cmd_len_out(cmd_len_out),
    .msg_valid_out(msg_valid_out), .msg_data_out(msg_data_out),
    .msg_index_out(msg_index_out), .drop_out(drop_out), .resp_ack_in(resp_ack_in),
    .resp_start_in(resp_start_in), .resp_len_in(resp_len_in),
    .resp_valid_in(resp_valid_in), .resp_data_in(resp_data_in),
    .resp_ready_out(resp_ready_out));
  sps_master i_sps_master (.mclk_in(mclk_in), .tx_in(tx_out), .line_out(rx_in));

  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge mclk_in) begin
    cyc++;
    if (cmd_valid_out === 1'b1) n_cmd++;
    if (drop_out === 1'b1) n_drop++;
    if (tx_oe_out === 1'b1) n_oe++;
    if (msg_valid_out === 1'b1) begin
      `CHK(msg_index_out, 6'(got_msg.size()))
      got_msg.push_back(msg_data_out);
    end
    if (cyc == CEIL) begin
      num_errors++;
      complete_run();
    end
  end

  function automatic logic [7:0] sum8(input logic [7:0] q[$]);
    sum8 = 8'h00;
    foreach (q[i]) sum8 += q[i];
  endfunction

  task automatic pkt(input logic [7:0] cmd, adr, input logic [7:0] msg[$],
                     input logic [7:0] bad, input int dc, input int dd);
    int c0, d0;
    c0 = n_cmd;
    d0 = n_drop;
    got_msg.delete();
    i_sps_master.send_pkt(cmd, adr, msg, bad);
    repeat (20) @(negedge mclk_in);
    `CHK(n_cmd - c0, dc)
    `CHK(n_drop - d0, dd)
  endtask

  // unfinished packet: expect one drop once the line has gone quiet
  task automatic part(input logic [7:0] q[$]);
    int d0;
    d0 = n_drop;
    foreach (q[i]) i_sps_master.send_byte(q[i]);
    repeat (GAP + 100) @(negedge mclk_in);
    `CHK(n_drop - d0, 1)
  endtask

  task automatic pulse(input bit ack);
    resp_ack_in = ack;
    resp_start_in = !ack;
    @(negedge mclk_in);
    resp_ack_in = 1'b0;
    resp_start_in = 1'b0;
  endtask

  task automatic feed(input logic [7:0] d[$]);
    foreach (d[i]) begin
      resp_valid_in = 1'b1;
      resp_data_in = d[i];
      while (resp_ready_out !== 1'b1) @(negedge mclk_in);
      @(negedge mclk_in);
    end
    resp_valid_in = 1'b0;
  endtask

  initial begin
    logic [7:0] q[$], rq[$], b, ua, wa, c;
    bit ok;
    int o0;
    {rst_n_in, resp_ack_in, resp_start_in, resp_valid_in} = 4'h0;
    {resp_len_in, resp_data_in} = 16'h0000;
    b = 8'($urandom(82));
    ua = 8'($urandom_range(255, 1));
    wa = (ua == 8'hff) ? 8'h01 : ua + 8'h01;
    unit_addr_in = ua;
    repeat (12) @(negedge mclk_in);
    rst_n_in = 1'b1;
    @(negedge mclk_in);
    `CHK(tx_out, 1'b1)
    `CHK(tx_oe_out, 1'b0)
    c = 8'($urandom);
    q = {8'($urandom)};
    pkt(c, ua, q, 8'h00, 1, 0);
    `CHK(cmd_out, c)
    `CHK(cmd_len_out, 8'h01)
    `CHK(cmd_bcast_out, 1'b0)
    `CHK(got_msg.size(), 1)
    `CHK(got_msg[0], q[0])
    pulse(1'b1);
    i_sps_master.recv_byte(b, ok);
    `CHK(ok, 1'b1)
    `CHK(b, ACK_BYTE)
    pkt(8'hd1, ua, e, 8'h00, 1, 0);
    rq = {8'($urandom), 8'($urandom)};
    resp_len_in = 8'h02;
    pulse(1'b0);
    fork
      feed(rq);
      for (int i = 0; i < 5; i++) begin
        i_sps_master.recv_byte(b, ok);
        rx_q.push_back(b);
      end
    join
    q = {ua, 8'h02, rq[0], rq[1]};
    q.push_back(sum8(q));
    foreach (q[i]) `CHK(rx_q[i], q[i])
    repeat (20) @(negedge mclk_in);
    o0 = n_oe;
    pkt(8'hd3, BCAST_ADDR, e, 8'h00, 1, 0);
    `CHK(cmd_bcast_out, 1'b1)
    pulse(1'b1);
    pkt(8'hd3, wa, e, 8'h00, 0, 0);
    pkt(8'hd4, ua, e, 8'h01, 0, 1);
    part({8'hd2, ua, 8'h31});
    part({8'hd2, ua});
    pkt(8'hd5, ua, e, 8'h00, 1, 0);
    `CHK(n_oe - o0, 0)
    complete_run();
  end
endmodule // sps_framer_tb
